/* pkg/irf_pkg.sv */
// Purpose: Constants, types and carriers for the interrupt request flag block.
// Assumes: Classic Wishbone slave, 32-bit data, 8-bit registers in the low byte.
// Notes: Offsets are byte addresses of aligned words.
package irf_pkg;
  localparam int ADDR_W = 8;
  localparam int EXT_N = 5;
  localparam int WAKE_N = 8;
  localparam int SRC_N = 14;
  localparam int SRC_W = 4;
  localparam logic [ADDR_W-1:0] OFS_FLAGS_ONE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FLAGS_TWO = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_WAKE_FLAGS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_WAKE_EDGE = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_ONE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_TWO = 8'h14;
  localparam logic [7:0] RST_FLAGS_ONE = 8'h20;
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  localparam logic [7:0] KEEP_ALL = 8'hFF;
  localparam logic [EXT_N-1:0] EXT_IDLE = 5'h1F;
  localparam logic [WAKE_N-1:0] WAKE_IDLE = 8'hFF;
  localparam logic [23:0] RD_PAD = 24'h00_0000;
  localparam logic [31:0] RD_NONE = 32'h0000_0000;
  localparam logic [SRC_W-1:0] SRC_NONE = 4'h0;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  // Bit positions in the first and second request registers and enables
  localparam int ONE_TIMER_A = 7;
  localparam int ONE_RSVD_RW = 6;
  localparam int ONE_FIXED = 5;
  localparam int TWO_DT = 7;
  localparam int TWO_AD = 6;
  localparam int TWO_RSVD_RW = 5;
  localparam int TWO_TG = 4;
  localparam int TWO_FH = 3;
  localparam int TWO_FL = 2;
  localparam int TWO_TC = 1;
  localparam int TWO_EC = 0;
  localparam int EN1_WAKEUP = 5;
  // Priority index: lower wins
  localparam int SRC_WAKEUP = 5;
  localparam int SRC_TIMER_A = 6;
  localparam int SRC_TWO_BASE = 7;
  typedef enum logic [1:0] {IRF_BUS_IDLE = 2'b01, IRF_BUS_ACK = 2'b10} irf_bus_e;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADDR_W-1:0] adr;
    logic [31:0] dat;
  } irf_wb_req_s;
  typedef struct packed {
    logic [EXT_N-1:0] ext_irq_mode;
    logic [EXT_N-1:0] ext_edge_rising;
    logic [WAKE_N-1:0] wakeup_mode;
    logic tg_capture_mode;
    logic tg_edge_rising;
  } irf_pin_cfg_s;
  typedef struct packed {
    logic [7:0] timer_a_count;
    logic sleep_executed;
    logic direct_transfer_on;
    logic conversion_busy_flag;
    logic timer_g_overflow;
    logic overflow_irq_enable;
    logic timer_f_16bit;
    logic [7:0] timer_f_upper_counter;
    logic [7:0] timer_f_upper_compare;
    logic [7:0] timer_f_lower_counter;
    logic [7:0] timer_f_lower_compare;
    logic [7:0] timer_c_count;
    logic event_counter_16bit;
    logic [7:0] event_counter_upper;
    logic [7:0] event_counter_lower;
  } irf_periph_s;
endpackage

/* design/irf_request_flags.sv */
// Purpose: Interrupt request flags, wakeup edge select, enables and request selection.
// Assumes: Peripheral inputs and CPU mask are on sys_clk; pins are asynchronous.
// Notes: Flags are sticky; software clears by writing 0, a set event wins over it.
//
// The address map and the Wishbone register port were decided locally.
module irf_request_flags
  import irf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire irf_wb_req_s wb_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic [EXT_N-1:0] external_request_pin_n,
  input wire logic [WAKE_N-1:0] wakeup_pin_n,
  input wire logic timer_g_capture_pin,
  input wire irf_pin_cfg_s pin_cfg,
  input wire irf_periph_s periph,
  input wire logic cpu_irq_mask,
  output logic irq_request,
  output logic [SRC_W-1:0] irq_source
);

  irf_bus_e bus_state_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic [7:0] flags_one_r;
  logic [7:0] flags_one_nxt;
  logic [7:0] flags_two_r;
  logic [7:0] flags_two_nxt;
  logic [7:0] wake_flags_r;
  logic [7:0] wake_flags_nxt;
  logic [7:0] wakeup_edge_select_r;
  logic [7:0] enable_one_r;
  logic [7:0] irq_enable_two_r;
  logic irq_request_r;
  logic [SRC_W-1:0] irq_source_r;

  logic [EXT_N-1:0] ext_s1_r;
  logic [EXT_N-1:0] ext_s2_r;
  logic [EXT_N-1:0] ext_prev_r;
  logic [WAKE_N-1:0] wake_s1_r;
  logic [WAKE_N-1:0] wake_s2_r;
  logic [WAKE_N-1:0] wake_prev_r;
  logic tg_s1_r;
  logic tg_s2_r;
  logic tg_prev_r;

  logic [7:0] ta_prev_r;
  logic [7:0] tc_prev_r;
  logic [7:0] ecu_prev_r;
  logic [7:0] ecl_prev_r;
  logic busy_prev_r;
  logic fh_match_prev_r;
  logic fl_match_prev_r;

  logic [EXT_N-1:0] ext_set;
  logic [WAKE_N-1:0] wake_set;
  logic [7:0] set_one;
  logic [7:0] set_two;
  logic ta_set;
  logic dt_set;
  logic ad_set;
  logic tg_set;
  logic fh_match;
  logic fl_match;
  logic tc_set;
  logic ecu_ovf;
  logic ecl_ovf;
  logic ec_set;

  logic bus_hit;
  logic wr_en;
  logic [7:0] wdat8;
  logic dec_one;
  logic dec_two;
  logic dec_wflags;
  logic dec_wedge;
  logic dec_en1;
  logic dec_en2;
  logic [7:0] rd8;
  logic rd_mapped;
  logic [7:0] keep_one;
  logic [7:0] keep_two;
  logic [7:0] keep_wake;
  logic [SRC_N-1:0] pending;

  // Edge of a synchronised level; rising selects low-to-high
  function automatic logic edge_hit(input logic prev, input logic cur, input logic rising);
    edge_hit = rising ? (~prev & cur) : (prev & ~cur);
  endfunction

  // Counter stepping from one fixed value to another between two samples
  function automatic logic steps(input logic [7:0] prev, input logic [7:0] cur,
                                 input logic [7:0] from_v, input logic [7:0] to_v);
    steps = (prev == from_v) && (cur == to_v);
  endfunction

  function automatic logic [SRC_W-1:0] first_set(input logic [SRC_N-1:0] v);
    first_set = SRC_NONE;
    for (int i = SRC_N - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        first_set = SRC_W'(i);
      end
    end
  endfunction

  // Pin synchronisers; the third stage only feeds edge detection
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ext_s1_r <= EXT_IDLE;
      ext_s2_r <= EXT_IDLE;
      ext_prev_r <= EXT_IDLE;
      wake_s1_r <= WAKE_IDLE;
      wake_s2_r <= WAKE_IDLE;
      wake_prev_r <= WAKE_IDLE;
      tg_s1_r <= 1'b0;
      tg_s2_r <= 1'b0;
      tg_prev_r <= 1'b0;
    end
    else
    begin
      ext_s1_r <= external_request_pin_n;
      ext_s2_r <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
      wake_s1_r <= wakeup_pin_n;
      wake_s2_r <= wake_s1_r;
      wake_prev_r <= wake_s2_r;
      tg_s1_r <= timer_g_capture_pin;
      tg_s2_r <= tg_s1_r;
      tg_prev_r <= tg_s2_r;
    end
  end

  // One-cycle set pulse per pin edge, so a held level sets the flag only once
  genvar g;
  generate
    for (g = 0; g < EXT_N; g++)
    begin : g_ext
      assign ext_set[g] = pin_cfg.ext_irq_mode[g] &
                          edge_hit(ext_prev_r[g], ext_s2_r[g], pin_cfg.ext_edge_rising[g]);
    end
    for (g = 0; g < WAKE_N; g++)
    begin : g_wake
      assign wake_set[g] = pin_cfg.wakeup_mode[g] &
                           edge_hit(wake_prev_r[g], wake_s2_r[g], wakeup_edge_select_r[g]);
    end
  endgenerate

  // Previous samples of peripheral state, used to see wraps and transitions
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ta_prev_r <= CNT_ZERO;
      tc_prev_r <= CNT_ZERO;
      ecu_prev_r <= CNT_ZERO;
      ecl_prev_r <= CNT_ZERO;
      busy_prev_r <= 1'b0;
      fh_match_prev_r <= 1'b0;
      fl_match_prev_r <= 1'b0;
    end
    else
    begin
      ta_prev_r <= periph.timer_a_count;
      tc_prev_r <= periph.timer_c_count;
      ecu_prev_r <= periph.event_counter_upper;
      ecl_prev_r <= periph.event_counter_lower;
      busy_prev_r <= periph.conversion_busy_flag;
      fh_match_prev_r <= fh_match;
      fl_match_prev_r <= fl_match;
    end
  end

  always_comb
  begin
    ta_set = steps(ta_prev_r, periph.timer_a_count, CNT_MAX, CNT_ZERO);
    dt_set = periph.sleep_executed & periph.direct_transfer_on;
    ad_set = busy_prev_r & ~periph.conversion_busy_flag;
    tg_set = (pin_cfg.tg_capture_mode & edge_hit(tg_prev_r, tg_s2_r, pin_cfg.tg_edge_rising)) |
             (periph.timer_g_overflow & periph.overflow_irq_enable);
    if (periph.timer_f_16bit)
    begin
      fh_match = {periph.timer_f_upper_counter, periph.timer_f_lower_counter} ==
                 {periph.timer_f_upper_compare, periph.timer_f_lower_compare};
    end
    else
    begin
      fh_match = periph.timer_f_upper_counter == periph.timer_f_upper_compare;
    end
    fl_match = ~periph.timer_f_16bit &
               (periph.timer_f_lower_counter == periph.timer_f_lower_compare);
    tc_set = steps(tc_prev_r, periph.timer_c_count, CNT_MAX, CNT_ZERO) |
             steps(tc_prev_r, periph.timer_c_count, CNT_ZERO, CNT_MAX);
    ecu_ovf = steps(ecu_prev_r, periph.event_counter_upper, CNT_MAX, CNT_ZERO);
    ecl_ovf = steps(ecl_prev_r, periph.event_counter_lower, CNT_MAX, CNT_ZERO);
    ec_set = periph.event_counter_16bit ? ecu_ovf : (ecu_ovf | ecl_ovf);
  end

  // A match that stays true sets once, at the cycle it begins
  always_comb
  begin
    set_one = RST_ZERO8;
    set_one[ONE_TIMER_A] = ta_set;
    set_one[EXT_N-1:0] = ext_set;
    set_two = RST_ZERO8;
    set_two[TWO_DT] = dt_set;
    set_two[TWO_AD] = ad_set;
    set_two[TWO_TG] = tg_set;
    set_two[TWO_FH] = fh_match & ~fh_match_prev_r;
    set_two[TWO_FL] = fl_match & ~fl_match_prev_r;
    set_two[TWO_TC] = tc_set;
    set_two[TWO_EC] = ec_set;
  end

  // Register decode; any unmapped address still gets an ack with zero data
  always_comb
  begin
    dec_one = 1'b0;
    dec_two = 1'b0;
    dec_wflags = 1'b0;
    dec_wedge = 1'b0;
    dec_en1 = 1'b0;
    dec_en2 = 1'b0;
    rd8 = RST_ZERO8;
    rd_mapped = 1'b1;
    if (wb_i.adr == OFS_FLAGS_ONE)
    begin
      dec_one = 1'b1;
      rd8 = flags_one_r;
    end
    else if (wb_i.adr == OFS_FLAGS_TWO)
    begin
      dec_two = 1'b1;
      rd8 = flags_two_r;
    end
    else if (wb_i.adr == OFS_WAKE_FLAGS)
    begin
      dec_wflags = 1'b1;
      rd8 = wake_flags_r;
    end
    else if (wb_i.adr == OFS_WAKE_EDGE)
    begin
      dec_wedge = 1'b1;
      rd8 = wakeup_edge_select_r;
    end
    else if (wb_i.adr == OFS_ENABLE_ONE)
    begin
      dec_en1 = 1'b1;
      rd8 = enable_one_r;
    end
    else if (wb_i.adr == OFS_ENABLE_TWO)
    begin
      dec_en2 = 1'b1;
      rd8 = irq_enable_two_r;
    end
    else
    begin
      rd_mapped = 1'b0;
    end
  end

  assign bus_hit = wb_i.cyc & wb_i.stb & (bus_state_r == IRF_BUS_IDLE);
  assign wr_en = bus_hit & wb_i.we & wb_i.sel[0];
  assign wdat8 = wb_i.dat[7:0];

  // Classic single-cycle slave: ack one cycle after the request, then one idle cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_state_r <= IRF_BUS_IDLE;
      ack_r <= 1'b0;
      dat_r <= RD_NONE;
    end
    else
    begin
      case (bus_state_r)
        IRF_BUS_IDLE:
        begin
          if (bus_hit)
          begin
            bus_state_r <= IRF_BUS_ACK;
            ack_r <= 1'b1;
            dat_r <= rd_mapped ? {RD_PAD, rd8} : RD_NONE;
          end
        end
        IRF_BUS_ACK:
        begin
          bus_state_r <= IRF_BUS_IDLE;
          ack_r <= 1'b0;
        end
        default:
        begin
          bus_state_r <= IRF_BUS_IDLE;
          ack_r <= 1'b0;
        end
      endcase
    end
  end

  // A write of 1 keeps a flag, 0 clears it; a set in the same cycle wins
  always_comb
  begin
    keep_one = (wr_en & dec_one) ? wdat8 : KEEP_ALL;
    keep_two = (wr_en & dec_two) ? wdat8 : KEEP_ALL;
    keep_wake = (wr_en & dec_wflags) ? wdat8 : KEEP_ALL;
    flags_one_nxt = (flags_one_r & keep_one) | set_one;
    flags_one_nxt[ONE_RSVD_RW] = (wr_en & dec_one) ? wdat8[ONE_RSVD_RW] : flags_one_r[ONE_RSVD_RW];
    flags_one_nxt[ONE_FIXED] = 1'b1;
    flags_two_nxt = (flags_two_r & keep_two) | set_two;
    flags_two_nxt[TWO_RSVD_RW] = (wr_en & dec_two) ? wdat8[TWO_RSVD_RW] : flags_two_r[TWO_RSVD_RW];
    wake_flags_nxt = (wake_flags_r & keep_wake) | wake_set;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      flags_one_r <= RST_FLAGS_ONE;
      flags_two_r <= RST_ZERO8;
      wake_flags_r <= RST_ZERO8;
    end
    else
    begin
      flags_one_r <= flags_one_nxt;
      flags_two_r <= flags_two_nxt;
      wake_flags_r <= wake_flags_nxt;
    end
  end

  // Edge select and enables are plain read/write
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wakeup_edge_select_r <= RST_ZERO8;
      enable_one_r <= RST_ZERO8;
      irq_enable_two_r <= RST_ZERO8;
    end
    else if (wr_en)
    begin
      if (dec_wedge)
      begin
        wakeup_edge_select_r <= wdat8;
      end
      if (dec_en1)
      begin
        enable_one_r <= wdat8;
      end
      if (dec_en2)
      begin
        irq_enable_two_r <= wdat8;
      end
    end
  end

  // Only enabled flags compete; the event-counter enable gates its request here
  always_comb
  begin
    pending[EXT_N-1:0] = flags_one_r[EXT_N-1:0] & enable_one_r[EXT_N-1:0];
    pending[SRC_WAKEUP] = (|wake_flags_r) & enable_one_r[EN1_WAKEUP];
    pending[SRC_TIMER_A] = flags_one_r[ONE_TIMER_A] & enable_one_r[ONE_TIMER_A];
    pending[SRC_TWO_BASE] = flags_two_r[TWO_DT] & irq_enable_two_r[TWO_DT];
    pending[SRC_TWO_BASE+1] = flags_two_r[TWO_AD] & irq_enable_two_r[TWO_AD];
    pending[SRC_TWO_BASE+2] = flags_two_r[TWO_TG] & irq_enable_two_r[TWO_TG];
    pending[SRC_TWO_BASE+3] = flags_two_r[TWO_FH] & irq_enable_two_r[TWO_FH];
    pending[SRC_TWO_BASE+4] = flags_two_r[TWO_FL] & irq_enable_two_r[TWO_FL];
    pending[SRC_TWO_BASE+5] = flags_two_r[TWO_TC] & irq_enable_two_r[TWO_TC];
    pending[SRC_TWO_BASE+6] = flags_two_r[TWO_EC] & irq_enable_two_r[TWO_EC];
  end

  // Masked requests stay pending in the flags; nothing here clears them
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      irq_request_r <= 1'b0;
      irq_source_r <= SRC_NONE;
    end
    else
    begin
      irq_request_r <= (|pending) & ~cpu_irq_mask;
      irq_source_r <= first_set(pending);
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign irq_request = irq_request_r;
  assign irq_source = irq_source_r;

endmodule

/* dv/irf_request_flags_assertions.sv */
// Purpose: Port-level checks for the request flag block.
// Assumes: One access at a time; a request is taken on its first edge.
// Notes: Shadows track software-owned bits and the timer A wrap.
module irf_request_flags_chk
  import irf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire irf_wb_req_s wb_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire irf_periph_s periph,
  input wire logic cpu_irq_mask,
  input wire logic irq_request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic req_q;
  logic ta_pend;
  logic rsvd1_sh;
  logic rsvd2_sh;
  logic [7:0] edge_sh;
  logic [7:0] ta_prev;
  logic req_take;
  logic wr_take;
  logic rd_ack;
  assign req_take = wb_i.cyc && wb_i.stb && !req_q;
  assign wr_take = req_take && wb_i.we && wb_i.sel[0];
  assign rd_ack = wb_ack_o && !wb_i.we;
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      req_q <= 1'b0;
      ta_prev <= CNT_ZERO;
      ta_pend <= 1'b0;
    end
    else
    begin
      req_q <= wb_i.cyc && wb_i.stb;
      ta_prev <= periph.timer_a_count;
      // A wrap in the clearing cycle wins
      if (periph.timer_a_count == CNT_ZERO && ta_prev == CNT_MAX)
        ta_pend <= 1'b1;
      else if (wr_take && wb_i.adr == OFS_FLAGS_ONE && !wb_i.dat[ONE_TIMER_A])
        ta_pend <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rsvd1_sh <= 1'b0;
      rsvd2_sh <= 1'b0;
      edge_sh <= RST_ZERO8;
    end
    else if (wr_take)
    begin
      if (wb_i.adr == OFS_FLAGS_ONE)
        rsvd1_sh <= wb_i.dat[ONE_RSVD_RW];
      if (wb_i.adr == OFS_FLAGS_TWO)
        rsvd2_sh <= wb_i.dat[TWO_RSVD_RW];
      if (wb_i.adr == OFS_WAKE_EDGE)
        edge_sh <= wb_i.dat[7:0];
    end
  end
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_NEXT: assert property (req_take |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_i.cyc && wb_i.stb))
    else $error("ack without request");
  AST_RD_PAD: assert property (rd_ack |-> wb_dat_o[31:8] == RD_PAD)
    else $error("upper read bytes not zero");
  AST_FIXED_BIT: assert property (rd_ack && wb_i.adr == OFS_FLAGS_ONE |-> wb_dat_o[ONE_FIXED])
    else $error("fixed bit read as 0");
  AST_RSVD_ONE: assert property (rd_ack && wb_i.adr == OFS_FLAGS_ONE |-> wb_dat_o[ONE_RSVD_RW] == $past(rsvd1_sh))
    else $error("spare bit of first register lost");
  AST_RSVD_TWO: assert property (rd_ack && wb_i.adr == OFS_FLAGS_TWO |-> wb_dat_o[TWO_RSVD_RW] == $past(rsvd2_sh))
    else $error("spare bit of second register lost");
  AST_EDGE_SEL: assert property (rd_ack && wb_i.adr == OFS_WAKE_EDGE |-> wb_dat_o[7:0] == $past(edge_sh))
    else $error("edge select readback wrong");
  AST_TA_SET: assert property (rd_ack && wb_i.adr == OFS_FLAGS_ONE && $past(ta_pend) |-> wb_dat_o[ONE_TIMER_A])
    else $error("timer A flag not set after wrap");
  AST_MASKED: assert property (cpu_irq_mask |=> !irq_request)
    else $error("request forwarded while masked");
  cover property (rd_ack && wb_i.adr == OFS_FLAGS_ONE && $past(ta_pend));
  cover property (wr_take);
  cover property (irq_request);
endmodule

bind irf_request_flags irf_request_flags_chk u_chk (
  .sys_clk(sys_clk), .rst(rst), .wb_i(wb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .periph(periph), .cpu_irq_mask(cpu_irq_mask), .irq_request(irq_request)
);

/* dv/irf_far_model.sv */
// Purpose: Far side: peripheral status, pins, pin modes and CPU mask.
// Assumes: Fields change by non-blocking assignment after a rising edge.
// Notes: Compare values start away from the idle counters.
module irf_far_model
  import irf_pkg::*;
(
  input wire logic sys_clk,
  output irf_pin_cfg_s pin_cfg,
  output irf_periph_s periph,
  output logic [EXT_N-1:0] external_request_pin_n,
  output logic [WAKE_N-1:0] wakeup_pin_n,
  output logic timer_g_capture_pin,
  output logic cpu_irq_mask
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    pin_cfg = '0;
    periph = '0;
    periph.timer_f_upper_compare = 8'h11;
    periph.timer_f_lower_compare = 8'h22;
    external_request_pin_n = EXT_IDLE;
    wakeup_pin_n = WAKE_IDLE;
    timer_g_capture_pin = 1'b0;
    cpu_irq_mask = 1'b1; // Start masked so clears are safe
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Counter moves to a, then to b one clock later
  task automatic count_step(input int which, input logic [7:0] a, input logic [7:0] b);
    logic [7:0] v;
    for (int i = 0; i < 2; i++)
    begin
      v = i ? b : a;
      case (which)
        0: periph.timer_a_count <= v;
        1: periph.timer_c_count <= v;
        2: periph.event_counter_lower <= v;
        default: periph.event_counter_upper <= v;
      endcase
      wait_cyc(1);
    end
  endtask
  // External pin n in interrupt mode with its edge select and level
  task automatic set_ext(input int n, input logic lvl, input logic rising);
    pin_cfg.ext_irq_mode[n] <= 1'b1;
    pin_cfg.ext_edge_rising[n] <= rising;
    external_request_pin_n[n] <= lvl;
  endtask
  task automatic set_wake(input logic [WAKE_N-1:0] mode, input logic [WAKE_N-1:0] lvl);
    pin_cfg.wakeup_mode <= mode;
    wakeup_pin_n <= lvl;
  endtask
  task automatic set_tg(input logic rising, input logic lvl);
    pin_cfg.tg_capture_mode <= 1'b1;
    pin_cfg.tg_edge_rising <= rising;
    timer_g_capture_pin <= lvl;
  endtask
  task automatic set_mask(input logic m);
    cpu_irq_mask <= m;
  endtask
  // Level fields take bit 0; the timer F counters take the whole byte
  task automatic set_level(input int which, input logic [7:0] v);
    case (which)
      0: periph.direct_transfer_on <= v[0];
      1: periph.conversion_busy_flag <= v[0];
      2: periph.overflow_irq_enable <= v[0];
      3: periph.timer_f_16bit <= v[0];
      4: periph.event_counter_16bit <= v[0];
      5: periph.timer_f_upper_counter <= v;
      default: periph.timer_f_lower_counter <= v;
    endcase
  endtask
  task automatic pulse(input int which);
    for (int i = 1; i >= 0; i--)
    begin
      if (which == 0)
        periph.sleep_executed <= i[0];
      else
        periph.timer_g_overflow <= i[0];
      wait_cyc(1);
    end
  endtask
endmodule

/* dv/irf_request_flags_tb.sv */
// Purpose: Self-checking bench for the request flag block.
// Assumes: Classic single-cycle bus accesses, one at a time.
// Notes: Pin and peripheral events come from the far-side model.
module irf_request_flags_tb
  import irf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk;
  logic rst;
  irf_wb_req_s wb_i;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic irq_request;
  logic [SRC_W-1:0] irq_source;
  irf_pin_cfg_s pin_cfg;
  irf_periph_s periph;
  logic [EXT_N-1:0] ext_n;
  logic [WAKE_N-1:0] wake_n;
  logic tg_pin;
  logic cpu_irq_mask;
  logic [7:0] junk;
  int error_cnt = 0;
  int checks_done = 0;

  irf_far_model far (.sys_clk(sys_clk), .pin_cfg(pin_cfg), .periph(periph), .external_request_pin_n(ext_n),
    .wakeup_pin_n(wake_n), .timer_g_capture_pin(tg_pin), .cpu_irq_mask(cpu_irq_mask));
  irf_request_flags dut (.sys_clk(sys_clk), .rst(rst), .wb_i(wb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .external_request_pin_n(ext_n), .wakeup_pin_n(wake_n), .timer_g_capture_pin(tg_pin), .pin_cfg(pin_cfg),
    .periph(periph), .cpu_irq_mask(cpu_irq_mask), .irq_request(irq_request), .irq_source(irq_source));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  // Holds the request until ack is sampled, then leaves one idle cycle
  task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                      output logic [7:0] r);
    int n;
    n = 0;
    wb_i <= {1'b1, 1'b1, we, s, a, RD_PAD, d};
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1)
    begin
      error_cnt++;
      print_verdict();
    end
    r = wb_dat_o[7:0];
    wb_i <= '0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    xfer(1'b1, a, d, 4'hF, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] r;
    xfer(1'b0, a, 8'h00, 4'hF, r);
    chk(nm, r, e);
  endtask

  // Pin events need a few cycles through the synchroniser
  task automatic expect_clr(input logic [7:0] a, input logic [7:0] e, input string nm);
    far.wait_cyc(6);
    rd_chk(a, e, nm);
    wr(a, 8'h00);
  endtask

  initial
  begin
    rst = 1'b1;
    wb_i = '0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(OFS_FLAGS_ONE, RST_FLAGS_ONE, "flags_one reset");
    rd_chk(OFS_FLAGS_TWO, RST_ZERO8, "flags_two reset");
    rd_chk(OFS_WAKE_EDGE, RST_ZERO8, "edge select reset");
    rd_chk(OFS_ENABLE_TWO, RST_ZERO8, "enable_two reset");
    rd_chk(8'h40, RST_ZERO8, "unmapped read");
    wr(OFS_FLAGS_ONE, 8'hDF);
    rd_chk(OFS_FLAGS_ONE, 8'h60, "flags_one spare bits");
    wr(OFS_FLAGS_TWO, 8'hFF);
    rd_chk(OFS_FLAGS_TWO, 8'h20, "flags_two spare bit");
    wr(OFS_FLAGS_TWO, 8'h00);
    wr(OFS_FLAGS_ONE, 8'h00);
    far.count_step(0, CNT_MAX, CNT_ZERO);
    wr(OFS_FLAGS_ONE, 8'hBF);
    rd_chk(OFS_FLAGS_ONE, 8'hA0, "timer a kept");
    wr(OFS_FLAGS_ONE, 8'h7F);
    rd_chk(OFS_FLAGS_ONE, 8'h60, "timer a cleared");
    wr(OFS_FLAGS_ONE, 8'h00);
    for (int n = 0; n < EXT_N; n++)
    begin
      far.set_ext(n, 1'b0, 1'b0);
      expect_clr(OFS_FLAGS_ONE, RST_FLAGS_ONE | (8'h01 << n), "external falling");
      far.set_ext(n, 1'b1, 1'b0);
      expect_clr(OFS_FLAGS_ONE, RST_FLAGS_ONE, "external rising ignored");
      far.set_ext(n, 1'b0, 1'b1);
      expect_clr(OFS_FLAGS_ONE, RST_FLAGS_ONE, "external falling ignored");
      far.set_ext(n, 1'b1, 1'b1);
      expect_clr(OFS_FLAGS_ONE, RST_FLAGS_ONE | (8'h01 << n), "external rising");
    end
    far.pulse(0);
    expect_clr(OFS_FLAGS_TWO, 8'h00, "sleep without transfer");
    far.set_level(0, 8'h01);
    far.pulse(0);
    expect_clr(OFS_FLAGS_TWO, 8'h80, "direct transfer");
    far.set_level(1, 8'h01);
    far.wait_cyc(2);
    far.set_level(1, 8'h00);
    expect_clr(OFS_FLAGS_TWO, 8'h40, "conversion done");
    far.pulse(1);
    expect_clr(OFS_FLAGS_TWO, 8'h00, "overflow disabled");
    far.set_level(2, 8'h01);
    far.pulse(1);
    expect_clr(OFS_FLAGS_TWO, 8'h10, "timer g overflow");
    far.set_tg(1'b1, 1'b1);
    expect_clr(OFS_FLAGS_TWO, 8'h10, "timer g capture");
    far.set_level(6, 8'h22);
    expect_clr(OFS_FLAGS_TWO, 8'h04, "lower match");
    far.set_level(5, 8'h11);
    expect_clr(OFS_FLAGS_TWO, 8'h08, "upper match");
    far.set_level(3, 8'h01);
    far.set_level(5, 8'h00);
    far.set_level(6, 8'h00);
    expect_clr(OFS_FLAGS_TWO, 8'h00, "wide idle");
    far.set_level(6, 8'h22);
    expect_clr(OFS_FLAGS_TWO, 8'h00, "wide half match");
    far.set_level(5, 8'h11);
    expect_clr(OFS_FLAGS_TWO, 8'h08, "wide match");
    far.count_step(1, CNT_ZERO, CNT_MAX);
    expect_clr(OFS_FLAGS_TWO, 8'h02, "timer c underflow");
    far.count_step(1, CNT_MAX, CNT_ZERO);
    expect_clr(OFS_FLAGS_TWO, 8'h02, "timer c overflow");
    far.count_step(2, CNT_MAX, CNT_ZERO);
    expect_clr(OFS_FLAGS_TWO, 8'h01, "event lower half");
    far.count_step(3, CNT_MAX, CNT_ZERO);
    expect_clr(OFS_FLAGS_TWO, 8'h01, "event upper half");
    far.set_level(4, 8'h01);
    far.count_step(2, CNT_MAX, CNT_ZERO);
    expect_clr(OFS_FLAGS_TWO, 8'h00, "wide event lower");
    far.count_step(3, CNT_MAX, CNT_ZERO);
    expect_clr(OFS_FLAGS_TWO, 8'h01, "wide event upper");
    wr(OFS_WAKE_EDGE, 8'hF0);
    rd_chk(OFS_WAKE_EDGE, 8'hF0, "edge select");
    // Byte lane 0 off: the write is acked but must not land
    xfer(1'b1, OFS_WAKE_EDGE, 8'h0F, 4'hE, junk);
    rd_chk(OFS_WAKE_EDGE, 8'hF0, "edge select lane off");
    far.set_wake(8'hFF, 8'h00);
    expect_clr(OFS_WAKE_FLAGS, 8'h0F, "wakeup falling");
    far.set_wake(8'hFF, 8'hFF);
    expect_clr(OFS_WAKE_FLAGS, 8'hF0, "wakeup rising");
    wr(OFS_ENABLE_ONE, 8'h80);
    far.count_step(0, CNT_MAX, CNT_ZERO);
    far.wait_cyc(3);
    chk("masked request", {7'h0, irq_request}, 8'h00);
    far.set_mask(1'b0);
    far.wait_cyc(3);
    chk("request", {7'h0, irq_request}, 8'h01);
    chk("source", {4'h0, irq_source}, 8'(SRC_TIMER_A));
    far.set_mask(1'b1);
    wr(OFS_FLAGS_ONE, 8'h00);
    wr(OFS_ENABLE_ONE, 8'h00);
    far.count_step(3, CNT_MAX, CNT_ZERO);
    far.set_mask(1'b0);
    far.wait_cyc(3);
    chk("event disabled", {7'h0, irq_request}, 8'h00);
    wr(OFS_ENABLE_TWO, 8'h01);
    far.wait_cyc(3);
    chk("event enabled", {7'h0, irq_request}, 8'h01);
    chk("event source", {4'h0, irq_source}, 8'(SRC_TWO_BASE + 6));
    far.set_mask(1'b1);
    wr(OFS_FLAGS_TWO, 8'h00);
    print_verdict();
  end
endmodule
